// [include/psp_defines.svh]
// register offsets, field positions, reset values and timing counts of the set picker
`ifndef PSP_DEFINES_SVH
`define PSP_DEFINES_SVH
`define PSP_OFF_CTRL 8'h00
`define PSP_OFF_INDEX 8'h04
`define PSP_OFF_CMD 8'h08
`define PSP_OFF_ACTIVE 8'h0C
`define PSP_OFF_STATUS 8'h10
`define PSP_CTRL_EN 0
`define PSP_CTRL_TOT_LO 1
`define PSP_CTRL_TOT_HI 3
`define PSP_CTRL_SWAP 4
`define PSP_CTRL_INV1 5
`define PSP_CTRL_INV2 6
`define PSP_CTRL_RESET 32'h0000_0004
`define PSP_CMD_STORE 0
`define PSP_CMD_LOAD 1
`define PSP_MAX_SETS 3'h4
`define PSP_MIN_SETS 3'h2
`define PSP_INDEX_MAX 32'h0000_0003
`define PSP_SETTLE_NS 1000
`define PSP_CLK_NS 5
`define PSP_SETTLE_CYC ((`PSP_SETTLE_NS + `PSP_CLK_NS - 1) / `PSP_CLK_NS)
`define PSP_RESP_OKAY 2'h0
`define PSP_RESP_SLVERR 2'h2
`endif

// [include/psp_pkg.sv]
// types shared by the set picker
package psp_pkg;
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_IDLE = 3'b010,
    ST_BUSY = 3'b100
  } psp_state_t;
  typedef logic [1:0] set_addr_t;
endpackage

// [core/free_select_param_set_picker.sv]
// free selection parameter set picker with AXI4-Lite registers
//
// Summary of operation
// R1 - accepted trigger loads addressed set into active; one accepted in ST_IDLE right after a disable loads saved_r instead
// R2 - more than two sets: two lines, else one
// R3 - set count capped at four
// R4 - address is binary set index, bit1 high
// R5 - two sets: only bit 0 selects set
// R6 - two sets: line 1 or 2 drives bit0
// R7 - more sets: line mapping or its reverse
// R8 - invert option flips line level to bit
// R9 - driver settles lines 1 us before trigger; trig_source set_lines waits only HOLD_CYC (12) clocks, 60 ns at 5 ns
// R10 - driver holds lines 1 us after trigger; trig_source holds them only for the HOLD_CYC (12) clock trigger pulse
// R11 - line change leaves waiting state briefly
// R12 - triggers while not waiting are ignored
// R13 - triggers only sent while device waits
// R14 - disable: finish frame, then restore saved active
// R15 - store copies active into indexed set
// R16 - index accepts only values 0 to 3
// R17 - captured address held for whole acquisition
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`include "psp_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module free_select_param_set_picker
  import psp_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int SETTLE_CYC = `PSP_SETTLE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic line1,
  input wire logic line2,
  input wire logic frame_trigger,
  input wire logic frame_done,
  output logic waiting_for_trigger,
  output logic capture_start,
  output logic [1:0] capture_addr,
  output logic [DATA_W-1:0] active_params
);

  function automatic logic known_offset(input logic [7:0] a);
    known_offset = (a == `PSP_OFF_CTRL) || (a == `PSP_OFF_INDEX) || (a == `PSP_OFF_CMD) ||
      (a == `PSP_OFF_ACTIVE) || (a == `PSP_OFF_STATUS);
  endfunction

  function automatic set_addr_t line_addr(input logic l1, input logic l2, input logic inv1,
      input logic inv2, input logic swap, input logic two_bits);
    logic b1;
    logic b2;
    b1 = l1 ^ inv1; // R8
    b2 = l2 ^ inv2; // R8
    if (two_bits) begin
      line_addr = swap ? {b1, b2} : {b2, b1}; // R4 R7
    end else begin
      line_addr = {1'b0, swap ? b2 : b1}; // R5 R6
    end
  endfunction

  logic [31:0] ctrl_r;
  logic [1:0] index_r;
  logic [DATA_W-1:0] active_r;
  logic [DATA_W-1:0] saved_r;
  logic [DATA_W-1:0] set_mem [0:3];
  psp_state_t state_r;
  logic [1:0] lines_prev_r;
  logic trig_prev_r;
  logic [15:0] settle_r;
  set_addr_t cap_addr_r;
  logic capture_r;
  logic aw_got_r;
  logic w_got_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  logic feature_on;
  logic [2:0] total_raw;
  logic [2:0] total_eff;
  logic two_bits;
  logic line_move;
  logic trig_rise;
  logic accept;
  set_addr_t addr_now;
  logic wr_go;
  logic rd_go;
  logic store_cmd;
  logic load_cmd;
  logic act_wr;

  assign feature_on = ctrl_r[`PSP_CTRL_EN];
  assign total_raw = ctrl_r[`PSP_CTRL_TOT_HI:`PSP_CTRL_TOT_LO];
  // counts above four fall back to four, below two act as two
  assign total_eff = (total_raw > `PSP_MAX_SETS) ? `PSP_MAX_SETS : // R3
    ((total_raw < `PSP_MIN_SETS) ? `PSP_MIN_SETS : total_raw);
  assign two_bits = total_eff > `PSP_MIN_SETS; // R2
  assign line_move = {line2, line1} != lines_prev_r;
  assign trig_rise = frame_trigger && !trig_prev_r;
  assign waiting_for_trigger = (state_r == ST_IDLE) && (settle_r == 16'h0000) && !line_move; // R11
  assign accept = waiting_for_trigger && trig_rise; // R12
  assign addr_now = line_addr(line1, line2, ctrl_r[`PSP_CTRL_INV1], ctrl_r[`PSP_CTRL_INV2],
    ctrl_r[`PSP_CTRL_SWAP], two_bits);
  assign capture_start = capture_r;
  assign capture_addr = cap_addr_r;
  assign active_params = active_r;

  // bus slave: address and data may come in either order
  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready = !w_got_r && !bvalid_r;
  assign wr_go = aw_got_r && w_got_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign rd_go = s_axi_arvalid && !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign store_cmd = wr_go && (awaddr_r == `PSP_OFF_CMD) && wdata_r[`PSP_CMD_STORE];
  assign load_cmd = wr_go && (awaddr_r == `PSP_OFF_CMD) && wdata_r[`PSP_CMD_LOAD];
  assign act_wr = wr_go && (awaddr_r == `PSP_OFF_ACTIVE);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      bvalid_r <= 1'b0;
      bresp_r <= `PSP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= known_offset(awaddr_r) ? `PSP_RESP_OKAY : `PSP_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // byte strobes ignored: every field is written whole
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_r <= `PSP_CTRL_RESET;
      index_r <= 2'h0;
    end else if (wr_go) begin
      if (awaddr_r == `PSP_OFF_CTRL) begin
        ctrl_r <= wdata_r & 32'h0000_007F;
      end
      if ((awaddr_r == `PSP_OFF_INDEX) && (wdata_r <= `PSP_INDEX_MAX)) begin
        index_r <= wdata_r[1:0]; // R16
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `PSP_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rresp_r <= known_offset(s_axi_araddr) ? `PSP_RESP_OKAY : `PSP_RESP_SLVERR;
      case (s_axi_araddr)
        `PSP_OFF_CTRL: rdata_r <= ctrl_r;
        `PSP_OFF_INDEX: rdata_r <= {30'h0000_0000, index_r};
        `PSP_OFF_ACTIVE: rdata_r <= 32'(active_r);
        `PSP_OFF_STATUS: rdata_r <= {24'h00_0000, state_r, addr_now, cap_addr_r,
          waiting_for_trigger};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // stored sets: no reset, contents are whatever software stored
  always_ff @(posedge clk) begin
    if (store_cmd) begin
      set_mem[index_r] <= active_r; // R15
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lines_prev_r <= 2'h0;
      trig_prev_r <= 1'b0;
      settle_r <= 16'h0000;
    end else begin
      lines_prev_r <= {line2, line1};
      trig_prev_r <= frame_trigger;
      // a moving line blocks triggers for a settle window after it
      if (line_move) begin
        settle_r <= 16'(SETTLE_CYC); // R11
      end else if (settle_r != 16'h0000) begin
        settle_r <= settle_r - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ST_OFF;
      saved_r <= '0;
    end else begin
      case (state_r)
        ST_OFF: begin
          if (feature_on) begin
            saved_r <= active_r;
            state_r <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (!feature_on) begin
            state_r <= ST_OFF;
          end else if (accept) begin
            state_r <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          // a disable here waits for the frame to be sent
          if (frame_done) begin
            state_r <= feature_on ? ST_IDLE : ST_OFF; // R14
          end
        end
        default: state_r <= ST_OFF;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cap_addr_r <= 2'h0;
      capture_r <= 1'b0;
    end else begin
      capture_r <= accept; // R12
      if (accept) begin
        cap_addr_r <= addr_now; // R17
      end
    end
  end

  logic restore;
  assign restore = !feature_on && (((state_r == ST_BUSY) && frame_done) || (state_r == ST_IDLE));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      active_r <= '0;
    end else if (restore) begin
      active_r <= saved_r; // R14
    end else if (accept) begin
      active_r <= set_mem[addr_now]; // R1
    end else if (load_cmd) begin
      active_r <= set_mem[index_r];
    end else if (act_wr) begin
      active_r <= wdata_r[DATA_W-1:0];
    end
  end

  logic [DATA_W-1:0] sel_val;
  assign sel_val = set_mem[addr_now];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_accept_plain;
    accept && feature_on && !restore;
  endsequence

  sequence seq_line_move_idle;
    line_move && (state_r == ST_IDLE);
  endsequence

  chk_accept_loads_set: assert property (seq_accept_plain |=> active_r == $past(sel_val)) // R1
    else $error("accepted trigger did not load the addressed set");
  chk_one_bit_addr: assert property (accept && !two_bits |=> cap_addr_r[1] == 1'b0) // R2 R5
    else $error("two set mode produced a high address bit");
  chk_total_capped: assert property (total_eff <= `PSP_MAX_SETS) // R3
    else $error("set count above four");
  chk_binary_addr: assert property (accept && two_bits && ctrl_r[6:4] == 3'h0
    |=> cap_addr_r == {$past(line2), $past(line1)}) // R4 R7
    else $error("address not binary from lines");
  chk_invert_line: assert property (accept && !two_bits && !ctrl_r[`PSP_CTRL_SWAP] &&
    ctrl_r[`PSP_CTRL_INV1] |=> cap_addr_r[0] == !$past(line1)) // R8
    else $error("inverted line not flipped");
  chk_swap_source: assert property (accept && ctrl_r[`PSP_CTRL_SWAP] &&
    !ctrl_r[`PSP_CTRL_INV2] |=> cap_addr_r[0] == $past(line2)) // R6 R7
    else $error("swapped line not on bit 0");
  chk_settle_not_wait: assert property (seq_line_move_idle |-> !waiting_for_trigger
    ##1 !waiting_for_trigger [*8]) // R11
    else $error("waiting shown while a line settles");
  chk_ignore_trigger: assert property (trig_rise && !waiting_for_trigger |=> !capture_start) // R12
    else $error("trigger taken while not waiting");
  chk_restore_after: assert property ((state_r == ST_BUSY) && !feature_on && frame_done
    |=> active_r == $past(saved_r) && state_r == ST_OFF) // R14
    else $error("active set not restored after frame");
  chk_store_copy: assert property (store_cmd |=> set_mem[$past(index_r)] == $past(active_r)) // R15
    else $error("store did not copy the active set");
  chk_index_range: assert property (wr_go && awaddr_r == `PSP_OFF_INDEX &&
    wdata_r > `PSP_INDEX_MAX |=> $stable(index_r)) // R16
    else $error("out of range index accepted");
  chk_addr_held: assert property ((state_r == ST_BUSY) ##1 (state_r == ST_BUSY)
    |-> $stable(cap_addr_r)) // R17
    else $error("captured address moved during acquisition");

endmodule
`default_nettype wire

// [verification/trig_source.sv]
// trigger source and selection line driver model for the set picker
`timescale 1ns/100ps
`default_nettype none
module trig_source #(
  parameter int HOLD_CYC = 12
) (
  input wire logic clk,
  input wire logic waiting_for_trigger,
  output logic line1,
  output logic line2,
  output logic frame_trigger,
  output logic frame_done
);
  initial begin
    line1 = 1'b0;
    line2 = 1'b0;
    frame_trigger = 1'b0;
    frame_done = 1'b0;
  end
  // lines settle longer than the device window before any trigger
  task automatic set_lines(input logic l1, input logic l2);
    @(posedge clk);
    line1 <= l1;
    line2 <= l2;
    repeat (HOLD_CYC) @(posedge clk);
  endtask
  // rude flips line1 with the trigger edge, breaking the waiting rule on purpose
  task automatic fire(input logic rude, output logic ok);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!rude && waiting_for_trigger !== 1'b1 && n < 400);
    ok = (n < 400);
    @(posedge clk);
    if (rude)
      line1 <= ~line1;
    frame_trigger <= 1'b1;
    // lines stay put while the trigger is held
    repeat (HOLD_CYC) @(posedge clk);
    frame_trigger <= 1'b0;
  endtask
  task automatic done_pulse;
    @(posedge clk);
    frame_done <= 1'b1;
    @(posedge clk);
    frame_done <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench for the parameter set picker
`include "psp_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench import psp_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, line1, line2, trig, fdone, waiting, cstart;
  logic [1:0] bresp, rresp, caddr;
  logic [31:0] rdata, active;
  int checks = 0, mismatches = 0, caps = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) if (cstart === 1'b1) caps <= caps + 1;
  free_select_param_set_picker #(.SETTLE_CYC(10)) i_dut (
    .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .line1(line1), .line2(line2), .frame_trigger(trig), .frame_done(fdone),
    .waiting_for_trigger(waiting), .capture_start(cstart), .capture_addr(caddr),
    .active_params(active));
  trig_source i_src (.clk(clk), .waiting_for_trigger(waiting), .line1(line1),
    .line2(line2), .frame_trigger(trig), .frame_done(fdone));
  function automatic logic [31:0] pv(input logic [1:0] a);
    return {16'hc0de, 14'h0000, a};
  endfunction
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic to_fail;
    mismatches++;
    $display("FAIL %0t wait timed out", $time);
    stop_test();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // ready is sampled on the falling edge; it cannot move before the next rise
  // bready and rready stay high between calls, so nothing drops and rises in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    for (int n = 0; n < 50 && !tb; n++) begin
      @(negedge clk);
      ta = awvalid && (awready === 1'b1);
      tw = wvalid && (wready === 1'b1);
      tb = (bvalid === 1'b1);
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    if (!tb) to_fail();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, t;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    t = 1'b0;
    for (int n = 0; n < 50 && !t; n++) begin
      @(negedge clk);
      ta = arvalid && (arready === 1'b1);
      t = (rvalid === 1'b1);
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end
    if (!t) to_fail();
  endtask
  task automatic cap(input logic l1, input logic l2, input logic [1:0] a);
    int c0;
    logic ok;
    i_src.set_lines(l1, l2);
    c0 = caps;
    i_src.fire(1'b0, ok);
    if (!ok) to_fail();
    chk(32'(caps - c0), 32'h0000_0001);
    chk(32'(caddr), 32'(a));
    chk(active, pv(a));
    i_src.done_pulse();
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic ok;
    int c0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`PSP_OFF_CTRL, d, r);
    chk(d, `PSP_CTRL_RESET);
    rd(8'h14, d, r);
    chk(32'(r), 32'(`PSP_RESP_SLVERR));
    for (int i = 0; i < 4; i++) begin
      wr(`PSP_OFF_INDEX, 32'(i), r);
      wr(`PSP_OFF_ACTIVE, pv(2'(i)), r);
      wr(`PSP_OFF_CMD, 32'h0000_0001, r);
    end
    wr(`PSP_OFF_INDEX, 32'h0000_0005, r);
    chk(32'(r), 32'(`PSP_RESP_OKAY));
    rd(`PSP_OFF_INDEX, d, r);
    chk(d, `PSP_INDEX_MAX);
    wr(8'h14, 32'h0000_0000, r);
    chk(32'(r), 32'(`PSP_RESP_SLVERR));
    wr(`PSP_OFF_CMD, 32'h0000_0002, r);
    chk(active, pv(2'h3));
    wr(`PSP_OFF_ACTIVE, 32'h5a5a_0000, r);
    $display("register test done");
    wr(`PSP_OFF_CTRL, 32'h0000_0009, r);
    for (int a = 0; a < 4; a++) cap(a[0], a[1], 2'(a));
    wr(`PSP_OFF_CTRL, 32'h0000_0039, r);
    for (int a = 0; a < 4; a++) cap(~a[1], a[0], 2'(a));
    wr(`PSP_OFF_CTRL, 32'h0000_000f, r);
    cap(1'b1, 1'b1, 2'h3);
    wr(`PSP_OFF_CTRL, 32'h0000_0005, r);
    cap(1'b1, 1'b1, 2'h1);
    wr(`PSP_OFF_CTRL, 32'h0000_0015, r);
    cap(1'b1, 1'b0, 2'h0);
    wr(`PSP_OFF_CTRL, 32'h0000_0055, r);
    cap(1'b0, 1'b0, 2'h1);
    wr(`PSP_OFF_CTRL, 32'h0000_0025, r);
    cap(1'b0, 1'b0, 2'h1);
    $display("selection test done");
    c0 = caps;
    i_src.fire(1'b1, ok);
    chk(32'(caps - c0), 32'h0000_0000);
    wr(`PSP_OFF_CTRL, 32'h0000_0009, r);
    i_src.set_lines(1'b0, 1'b1);
    i_src.fire(1'b0, ok);
    i_src.set_lines(1'b1, 1'b1);
    chk(32'(caddr), 32'h0000_0002);
    wr(`PSP_OFF_CTRL, 32'h0000_0008, r);
    chk(active, pv(2'h2));
    i_src.done_pulse();
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(active, 32'h5a5a_0000);
    @(posedge clk);
    rd(`PSP_OFF_STATUS, d, r);
    chk(d, 32'h0000_003c);
    $display("restore test done");
    stop_test();
  end
endmodule
`default_nettype wire
